// File: logic/fcd_params.svh
// constants of the flow control opcode decoder
`ifndef FCD_PARAMS_SVH
`define FCD_PARAMS_SVH
// instruction word field layout
`define FCD_BARRIER_BIT   31
`define FCD_RSVD_BIT      30
`define FCD_OP_MSB        29
`define FCD_OP_LSB        22
`define FCD_CNT_MSB       15
`define FCD_CNT_LSB       10
`define FCD_POPCNT_MSB    9
`define FCD_POPCNT_LSB    7
`define FCD_COND_BIT      5
`define FCD_POP_ONE       3'h1
// opcodes
`define FCD_OP_QUAD_PUSH   8'h22
`define FCD_OP_QUAD_POP    8'h23
`define FCD_OP_QUAD_ELSE   8'h24
`define FCD_OP_JUMP_ANY    8'h25
`define FCD_OP_THR_REVIVE  8'h26
`define FCD_OP_QUAD_REVIVE 8'h27
`define FCD_OP_IRQ         8'h28
`define FCD_OP_IRQ_SLEEP   8'h29
`define FCD_OP_SET_PRIO    8'h2a
// apb map, byte addresses
`define FCD_ADDR_CTRL   8'h00
`define FCD_ADDR_IDX0   8'h04
`define FCD_ADDR_IDX1   8'h08
`define FCD_ADDR_STATUS 8'h0c
`define FCD_ADDR_PRIO   8'h10
`define FCD_ADDR_WAKE   8'h14
`define FCD_ADDR_ERR    8'h18
// ctrl fields
`define FCD_CTRL_VIRTUAL_MEM_CONTEXT_ID_LSB 0
`define FCD_CTRL_RING_LSB 8
`define FCD_CTRL_SE_LSB   12
// status fields
`define FCD_ST_DEPTH_LSB  16
`define FCD_ST_SLEEP_BIT  24
`define FCD_ST_BUSY_BIT   25
// error bits
`define FCD_ERR_POPCNT   0
`define FCD_ERR_OVER     1
`define FCD_ERR_UNDER    2
`define FCD_ERR_UNSUPP   3
`define FCD_ERR_W        4
`endif

// File: logic/fcd_pkg.sv
// types shared by the flow control opcode decoder
package fcd_pkg;
  typedef enum logic [1:0] {
    FCD_IDLE  = 2'b01,
    FCD_FETCH = 2'b10
  } fcd_state_e;

  typedef struct packed {
    logic [15:0] flow_index_zero;
    logic [15:0] flow_index_one;
    logic [3:0]  virtual_mem_context_id;
    logic [1:0]  command_ring_number;
    logic [1:0]  engine_id;
  } fcd_irq_data_s;

  typedef struct packed {
    logic          valid;
    logic          sleep;
    fcd_irq_data_s data;
  } fcd_irq_s;
endpackage

// File: logic/fcd_lane_stack.sv
// branch stack of lane masks with registered top read
`timescale 1ns/1ns
module fcd_lane_stack #(
  parameter int W     = 16,
  parameter int DEPTH = 8,
  parameter int PW    = $clog2(DEPTH + 1)
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic          rd_req,
  input  wire logic [W-1:0]  wdata,
  output logic      [W-1:0]  rd_data,
  output logic      [PW-1:0] depth
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           ptr;
    logic [W-1:0]            rd;
  } stk_s;
  stk_s s_q;
  stk_s s_d;

  initial
  begin
    if (DEPTH < 1 || DEPTH > 255) $error("stack depth out of range");
  end

  always_comb
  begin
    s_d = s_q;
    if (push && s_q.ptr < PW'(DEPTH))
    begin
      s_d.mem[s_q.ptr[$clog2(DEPTH)-1 + (DEPTH == 1):0]] = wdata;
      s_d.ptr = s_q.ptr + PW'(1);
    end
    else if (pop && s_q.ptr != '0)
      s_d.ptr = s_q.ptr - PW'(1);
    if (rd_req && s_q.ptr != '0)
      s_d.rd = s_q.mem[s_q.ptr - PW'(1)];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rd_data = s_q.rd;
  assign depth   = s_q.ptr;
endmodule

// File: logic/fcd_barrier_track.sv
// count of issued flow instructions not yet completed
`timescale 1ns/1ns
module fcd_barrier_track #(
  parameter int MAX_OUT = 15,
  parameter int CW      = $clog2(MAX_OUT + 1)
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic issue,
  input  wire logic retire,
  output logic      all_done,
  output logic      full
);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } bt_s;
  bt_s s_q;
  bt_s s_d;

  initial
  begin
    if (MAX_OUT < 1) $error("outstanding limit must be positive");
  end

  always_comb
  begin
    s_d = s_q;
    // retire with nothing outstanding is a far-side fault; ignored
    if (issue && !(retire && s_q.cnt != '0))
      s_d.cnt = s_q.cnt + CW'(1);
    else if (retire && !issue && s_q.cnt != '0)
      s_d.cnt = s_q.cnt - CW'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign all_done = (s_q.cnt == '0);
  assign full     = (s_q.cnt == CW'(MAX_OUT));
endmodule

// File: logic/fcd_decoder.sv
// flow control decoder for opcodes 34 to 42 with apb status and control
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "fcd_params.svh"
module fcd_decoder #(
  parameter int LANES       = 16,
  parameter int STACK_DEPTH = 8,
  parameter int MAX_OUT     = 15
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  input  wire logic [31:0]       flow_word,
  input  wire logic [LANES-1:0]  cond_pass,
  input  wire logic [LANES-1:0]  lane_valid,
  input  wire logic              in_loop,
  input  wire logic              cf_done,
  output logic                   jump_take,
  output logic [LANES-1:0]       active_mask,
  output logic [5:0]             prio,
  output logic                   sleeping,
  output fcd_pkg::fcd_irq_s      irq_out
);
  import fcd_pkg::*;

  localparam int PW = $clog2(STACK_DEPTH + 1);

  initial
  begin
    if (LANES < 4 || LANES > 16 || (LANES % 4) != 0) $error("lanes must be 4, 8, 12 or 16");
    if (STACK_DEPTH > 255) $error("stack too deep for status field");
  end

  typedef struct packed {
    fcd_state_e          st;
    logic [7:0]          op;
    logic                cond;
    logic [LANES-1:0]    act;
    logic [PW-1:0]       frames;
    logic                jump;
    logic [5:0]          prio;
    logic                sleep;
    fcd_irq_s            irq;
    logic [15:0]         idx0;
    logic [15:0]         idx1;
    logic [15:0]         ctrl;
    logic [`FCD_ERR_W-1:0] err;
    logic [31:0]         rdata;
    logic                slverr;
  } dec_s;
  dec_s s_q;
  dec_s s_d;

  logic              stk_push;
  logic              stk_pop;
  logic              stk_rd;
  logic [LANES-1:0]  stk_top;
  logic [PW-1:0]     stk_depth;
  logic              bt_all_done;
  logic              bt_full;
  logic              accept;
  logic              apb_wr;
  logic              apb_rd;
  logic [7:0]        opcode;
  logic              barrier;
  logic              cond_en;
  logic [2:0]        pop_cnt;
  logic [5:0]        cnt_field;

  // any live lane lights its whole quad
  function automatic logic [LANES-1:0] quad_expand(input logic [LANES-1:0] m);
    logic [LANES-1:0] r;
    r = '0;
    for (int q = 0; q < LANES / 4; q++)
      r[q*4 +: 4] = {4{|m[q*4 +: 4]}};
    return r;
  endfunction

  fcd_lane_stack #(
    .W     (LANES),
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (stk_push),
    .pop     (stk_pop),
    .rd_req  (stk_rd),
    .wdata   (s_q.act),
    .rd_data (stk_top),
    .depth   (stk_depth)
  );

  fcd_barrier_track #(
    .MAX_OUT (MAX_OUT)
  ) u_barrier (
    .pclk     (pclk),
    .presetn  (presetn),
    .issue    (accept),
    .retire   (cf_done),
    .all_done (bt_all_done),
    .full     (bt_full)
  );

  // bit 30 is never decoded
  assign opcode    = flow_word[`FCD_OP_MSB:`FCD_OP_LSB];
  assign barrier   = flow_word[`FCD_BARRIER_BIT];
  assign cond_en   = flow_word[`FCD_COND_BIT];
  assign pop_cnt   = flow_word[`FCD_POPCNT_MSB:`FCD_POPCNT_LSB];
  assign cnt_field = flow_word[`FCD_CNT_MSB:`FCD_CNT_LSB];

  // unset barrier lets the word through with work still outstanding
  // set barrier holds it until every earlier one has retired
  assign instr_ready = (s_q.st == FCD_IDLE) && !s_q.sleep && !bt_full && (!barrier || bt_all_done);
  assign accept      = instr_valid && instr_ready;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  always_comb
  begin
    logic [LANES-1:0] m;
    logic [`FCD_ERR_W-1:0] err_set;
    m        = '0;
    err_set  = '0;
    s_d      = s_q;
    stk_push = 1'b0;
    stk_pop  = 1'b0;
    stk_rd   = 1'b0;
    s_d.jump = 1'b0;
    s_d.irq.valid = 1'b0;
    s_d.irq.sleep = 1'b0;

    case (s_q.st)
      FCD_IDLE:
      begin
        if (accept)
        begin
          s_d.op   = opcode;
          s_d.cond = cond_en;
          if (opcode == `FCD_OP_QUAD_PUSH)
          begin
            if (s_q.act == '0)
              s_d.jump = 1'b1;
            else if (stk_depth == PW'(STACK_DEPTH))
              err_set[`FCD_ERR_OVER] = 1'b1;
            else
            begin
              stk_push   = 1'b1;
              s_d.act    = quad_expand(s_q.act);
              s_d.frames = s_q.frames + PW'(1);
            end
          end
          else if (opcode == `FCD_OP_QUAD_POP || opcode == `FCD_OP_QUAD_ELSE)
          begin
            if (opcode == `FCD_OP_QUAD_POP && pop_cnt != `FCD_POP_ONE)
              err_set[`FCD_ERR_POPCNT] = 1'b1;
            else if (stk_depth == '0)
              err_set[`FCD_ERR_UNDER] = 1'b1;
            else
            begin
              stk_rd = 1'b1;
              s_d.st = FCD_FETCH;
            end
          end
          else if (opcode == `FCD_OP_THR_REVIVE || opcode == `FCD_OP_QUAD_REVIVE)
          begin
            // loop and quad frame use is unsupported; flagged, not executed
            if (in_loop || s_q.frames != '0)
              err_set[`FCD_ERR_UNSUPP] = 1'b1;
            else if (stk_depth == '0)
              err_set[`FCD_ERR_UNDER] = 1'b1;
            else
            begin
              stk_rd = 1'b1;
              s_d.st = FCD_FETCH;
            end
          end
          else if (opcode == `FCD_OP_JUMP_ANY)
            s_d.jump = cond_en ? |(s_q.act & cond_pass) : 1'b1;
          else if (opcode == `FCD_OP_IRQ || opcode == `FCD_OP_IRQ_SLEEP)
          begin
            s_d.irq.valid = 1'b1;
            s_d.irq.data.flow_index_zero        = s_q.idx0;
            s_d.irq.data.flow_index_one         = s_q.idx1;
            s_d.irq.data.virtual_mem_context_id = s_q.ctrl[`FCD_CTRL_VIRTUAL_MEM_CONTEXT_ID_LSB +: 4];
            s_d.irq.data.command_ring_number    = s_q.ctrl[`FCD_CTRL_RING_LSB +: 2];
            s_d.irq.data.engine_id              = s_q.ctrl[`FCD_CTRL_SE_LSB +: 2];
            if (opcode == `FCD_OP_IRQ_SLEEP)
            begin
              s_d.irq.sleep = 1'b1;
              s_d.sleep     = 1'b1;
            end
          end
          else if (opcode == `FCD_OP_SET_PRIO)
            s_d.prio = cnt_field;
        end
      end
      FCD_FETCH:
      begin
        // stack top register was loaded on the accept edge
        s_d.st = FCD_IDLE;
        if (s_q.op == `FCD_OP_QUAD_POP)
        begin
          stk_pop    = 1'b1;
          s_d.act    = stk_top;
          s_d.jump   = (stk_top == '0);
          s_d.frames = (s_q.frames != '0) ? s_q.frames - PW'(1) : s_q.frames;
        end
        else if (s_q.op == `FCD_OP_QUAD_ELSE)
        begin
          m        = stk_top & ~s_q.act & (s_q.cond ? cond_pass : {LANES{1'b1}});
          m        = quad_expand(m);
          s_d.act  = m;
          s_d.jump = (m == '0);
        end
        else if (s_q.op == `FCD_OP_THR_REVIVE)
          s_d.act = stk_top & lane_valid;
        else
          s_d.act = quad_expand(stk_top & lane_valid);
      end
      default:
        s_d.st = FCD_IDLE;
    endcase

    // apb: zero wait, reads registered in setup phase
    s_d.slverr = 1'b0;
    if (apb_rd)
    begin
      s_d.rdata = '0;
      if (paddr == `FCD_ADDR_CTRL)
        s_d.rdata[15:0] = s_q.ctrl;
      else if (paddr == `FCD_ADDR_IDX0)
        s_d.rdata[15:0] = s_q.idx0;
      else if (paddr == `FCD_ADDR_IDX1)
        s_d.rdata[15:0] = s_q.idx1;
      else if (paddr == `FCD_ADDR_STATUS)
      begin
        s_d.rdata[LANES-1:0]                  = s_q.act;
        s_d.rdata[`FCD_ST_DEPTH_LSB +: PW]    = stk_depth;
        s_d.rdata[`FCD_ST_SLEEP_BIT]          = s_q.sleep;
        s_d.rdata[`FCD_ST_BUSY_BIT]           = !bt_all_done;
      end
      else if (paddr == `FCD_ADDR_PRIO)
        s_d.rdata[5:0] = s_q.prio;
      else if (paddr == `FCD_ADDR_ERR)
        s_d.rdata[`FCD_ERR_W-1:0] = s_q.err;
      else if (paddr != `FCD_ADDR_WAKE)
        s_d.slverr = 1'b1;
    end
    else if (psel && !penable && pwrite)
    begin
      if (paddr != `FCD_ADDR_CTRL && paddr != `FCD_ADDR_IDX0 && paddr != `FCD_ADDR_IDX1
          && paddr != `FCD_ADDR_WAKE && paddr != `FCD_ADDR_ERR)
        s_d.slverr = 1'b1;
    end
    else if (!(psel && penable))
      s_d.rdata = '0;

    if (apb_wr)
    begin
      if (paddr == `FCD_ADDR_CTRL)
        s_d.ctrl = pwdata[15:0];
      else if (paddr == `FCD_ADDR_IDX0)
        s_d.idx0 = pwdata[15:0];
      else if (paddr == `FCD_ADDR_IDX1)
        s_d.idx1 = pwdata[15:0];
      // a sleep raised in this same cycle outlasts the wake write
      else if (paddr == `FCD_ADDR_WAKE && pwdata[0] && !s_d.irq.sleep)
        s_d.sleep = 1'b0;
      else if (paddr == `FCD_ADDR_ERR)
        s_d.err = s_q.err & ~pwdata[`FCD_ERR_W-1:0];
    end
    // new error in the clearing cycle is kept
    s_d.err = s_d.err | err_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q    <= '0;
      s_q.st <= FCD_IDLE;
      // every lane live out of reset, else a push never has a mask to save
      s_q.act <= '1;
    end
    else
      s_q <= s_d;
  end

  assign prdata      = s_q.rdata;
  assign pready      = 1'b1;
  assign pslverr     = s_q.slverr && psel && penable;
  assign jump_take   = s_q.jump;
  assign active_mask = s_q.act;
  assign prio        = s_q.prio;
  assign sleeping    = s_q.sleep;
  assign irq_out     = s_q.irq;
endmodule

// File: verification/fcd_decoder_sva.sv
// port assertions for the flow control decoder
`timescale 1ns/1ns
`include "fcd_params.svh"
module fcd_decoder_chk
  import fcd_pkg::*;
#(
  parameter int LANES = 16
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             instr_valid,
  input wire logic             instr_ready,
  input wire logic [31:0]      flow_word,
  input wire logic             in_loop,
  input wire logic             cf_done,
  input wire logic             jump_take,
  input wire logic [LANES-1:0] active_mask,
  input wire logic [5:0]       prio,
  input wire logic             sleeping,
  input wire fcd_irq_s         irq_out
);
  logic       acc;
  logic [7:0] op;
  logic [4:0] open_q;
  logic [4:0] open_d;
  assign acc = instr_valid && instr_ready;
  assign op  = flow_word[`FCD_OP_MSB:`FCD_OP_LSB];
  // own count of unfinished words, so the barrier check needs no internals
  always_comb open_d = open_q + 5'(acc) - 5'(cf_done);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      open_q <= 5'h00;
    else
      open_q <= open_d;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_push_none_jump: assert property (acc && op == `FCD_OP_QUAD_PUSH && active_mask == '0 |=> jump_take)
    else $error("empty quad push did not jump");
  a_pop_bad_cnt: assert property (acc && op == `FCD_OP_QUAD_POP && flow_word[9:7] != `FCD_POP_ONE |=> !jump_take [*2])
    else $error("refused pop jumped");
  a_jump_any_go: assert property (acc && op == `FCD_OP_JUMP_ANY && !flow_word[`FCD_COND_BIT] |=> jump_take)
    else $error("plain jump any not taken");
  a_revive_loop: assert property (acc && in_loop && (op == `FCD_OP_THR_REVIVE || op == `FCD_OP_QUAD_REVIVE)
    |=> $stable(active_mask) [*2])
    else $error("revive in loop changed mask");
  a_irq_plain: assert property (acc && op == `FCD_OP_IRQ |=> irq_out.valid && !irq_out.sleep)
    else $error("interrupt pulse missing");
  a_irq_sleep: assert property (acc && op == `FCD_OP_IRQ_SLEEP |=> irq_out.valid && irq_out.sleep && sleeping)
    else $error("interrupt with sleep wrong");
  a_sleep_stall: assert property (sleeping |-> !instr_ready)
    else $error("ready while asleep");
  a_prio_load: assert property (acc && op == `FCD_OP_SET_PRIO |=> prio == $past(flow_word[15:10]))
    else $error("priority not loaded from count");
  a_barrier_hold: assert property (instr_valid && flow_word[`FCD_BARRIER_BIT] && open_q != 5'h00 |-> !instr_ready)
    else $error("barrier word taken early");
endmodule

bind fcd_decoder fcd_decoder_chk #(.LANES(LANES)) u_chk (
  .pclk(pclk), .presetn(presetn), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .flow_word(flow_word), .in_loop(in_loop), .cf_done(cf_done), .jump_take(jump_take),
  .active_mask(active_mask), .prio(prio), .sleeping(sleeping), .irq_out(irq_out)
);

// File: verification/fcd_seq_model.sv
// program sequencer model offering flow words
`timescale 1ns/1ns
module fcd_seq_model (
  input  wire logic  pclk,
  input  wire logic  instr_ready,
  output logic       instr_valid,
  output logic [31:0] flow_word,
  output logic       cf_done
);
  initial
  begin
    instr_valid = 1'b0;
    flow_word   = 32'h0;
    cf_done     = 1'b0;
  end
  task automatic send(input logic [31:0] w, input bit done, input int gap, output bit ok);
    bit r;
    int n;
    r = 1'b0;
    n = 0;
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    instr_valid <= 1'b1;
    flow_word   <= w;
    while (!r && n < 50)
    begin
      @(posedge pclk);
      r = (instr_ready === 1'b1);
      n++;
    end
    instr_valid <= 1'b0;
    // inverted idle word, so a stale word is never mistaken for a new one
    flow_word   <= ~w;
    cf_done     <= done;
    @(posedge pclk);
    cf_done <= 1'b0;
    ok = r;
  endtask
  task automatic retire();
    @(posedge pclk);
    cf_done <= 1'b1;
    @(posedge pclk);
    cf_done <= 1'b0;
  endtask
endmodule

// File: verification/flow_control_opcode_decoder_tb_top.sv
// self-checking bench for the flow control decoder
`timescale 1ns/1ns
`include "fcd_params.svh"
module flow_control_opcode_decoder_tb_top;
  import fcd_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, in_loop;
  logic          cf_done, instr_valid, instr_ready, jump_take, sleeping, er, ok;
  logic [7:0]    paddr;
  logic [5:0]    prio, c;
  logic [15:0]   cond_pass, lane_valid, active_mask;
  logic [31:0]   pwdata, prdata, flow_word, rd, ctl, ix0, ix1;
  fcd_irq_data_s d;
  fcd_irq_s      irq_out;
  fcd_irq_s      exp_irq[$];
  logic          exp_jmp[$];
  int            n_fail, samples_checked;

  fcd_decoder DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .flow_word(flow_word),
    .cond_pass(cond_pass), .lane_valid(lane_valid), .in_loop(in_loop), .cf_done(cf_done),
    .jump_take(jump_take), .active_mask(active_mask), .prio(prio), .sleeping(sleeping),
    .irq_out(irq_out)
  );
  fcd_seq_model u_seq (
    .pclk(pclk), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .flow_word(flow_word), .cf_done(cf_done)
  );

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a slave that never answers
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // whole quad mode: any live lane lights its quad
  function automatic logic [15:0] qx(logic [15:0] m);
    for (int q = 0; q < 4; q++)
      m[q*4 +: 4] = {4{|m[q*4 +: 4]}};
    return m;
  endfunction

  function automatic logic [31:0] fw(logic [7:0] op, logic b, logic [5:0] n, logic [2:0] pc, logic cd);
    return {b, 1'($urandom), op, 6'($urandom), n, pc, 1'($urandom), cd, 5'($urandom)};
  endfunction

  task automatic snd(input logic [31:0] w, input bit done);
    u_seq.send(w, done, $urandom_range(2), ok);
    chk(ok, 1'b1);
  endtask

  task automatic endtest(input string s);
    repeat (3) @(posedge pclk);
    chk(exp_jmp.size() + exp_irq.size(), 0);
    $display("test %s finished", s);
  endtask

  // results are matched against the oldest outstanding note
  always @(negedge pclk)
  begin
    if (presetn === 1'b1 && irq_out.valid === 1'b1)
      chk(irq_out, exp_irq.size() > 0 ? exp_irq.pop_front() : '0);
    if (presetn === 1'b1 && jump_take === 1'b1)
      chk(exp_jmp.size() > 0 ? exp_jmp.pop_front() : 1'b0, 1'b1);
  end

  initial
  begin
    #(3000 * 100);
    n_fail++;
    summarize();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, in_loop, presetn} = '0;
    void'($urandom(87));
    cond_pass  = 16'($urandom);
    lane_valid = 16'($urandom);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(instr_ready, 1'b1);
    chk(active_mask, 16'hffff);
    snd(fw(`FCD_OP_QUAD_PUSH, 1'b0, 6'h0, 3'h0, 1'b0), 1'b1);
    apb(1'b0, `FCD_ADDR_STATUS, 32'h0);
    chk(rd[23:0], 24'h01ffff);
    // else with every lane already live leaves none and jumps
    exp_jmp.push_back(1'b1);
    snd(fw(`FCD_OP_QUAD_ELSE, 1'b0, 6'h0, 3'h0, 1'b0), 1'b1);
    @(negedge pclk);
    chk(active_mask, 16'h0);
    exp_jmp.push_back(1'b1);
    snd(fw(`FCD_OP_QUAD_PUSH, 1'b0, 6'h0, 3'h0, 1'b0), 1'b1);
    if (qx(cond_pass) == 16'h0) exp_jmp.push_back(1'b1);
    snd(fw(`FCD_OP_QUAD_ELSE, 1'b0, 6'h0, 3'h0, 1'b1), 1'b1);
    @(negedge pclk);
    chk(active_mask, qx(cond_pass));
    snd(fw(`FCD_OP_QUAD_POP, 1'b0, 6'h0, 3'h1, 1'b0), 1'b1);
    @(negedge pclk);
    chk(active_mask, 16'hffff);
    apb(1'b0, `FCD_ADDR_STATUS, 32'h0);
    chk(rd[23:16], 8'h0);
    endtest("quad");
    exp_jmp.push_back(1'b1);
    snd(fw(`FCD_OP_JUMP_ANY, 1'b0, 6'h0, 3'h0, 1'b0), 1'b1);
    if (cond_pass != 16'h0) exp_jmp.push_back(1'b1);
    snd(fw(`FCD_OP_JUMP_ANY, 1'b0, 6'h0, 3'h0, 1'b1), 1'b1);
    endtest("jump");
    repeat (4)
    begin
      c = 6'($urandom);
      snd(fw(`FCD_OP_SET_PRIO, 1'b0, c, 3'h0, 1'b0), 1'b1);
      chk(prio, c);
    end
    endtest("prio");
    {ctl, ix0, ix1} = {$urandom, $urandom, $urandom};
    apb(1'b1, `FCD_ADDR_CTRL, ctl);
    apb(1'b1, `FCD_ADDR_IDX0, ix0);
    apb(1'b1, `FCD_ADDR_IDX1, ix1);
    apb(1'b0, `FCD_ADDR_IDX0, 32'h0);
    chk(rd, {16'h0, ix0[15:0]});
    d = {ix0[15:0], ix1[15:0], ctl[3:0], ctl[9:8], ctl[13:12]};
    exp_irq.push_back({2'b10, d});
    snd(fw(`FCD_OP_IRQ, 1'b0, 6'h0, 3'h0, 1'b0), 1'b1);
    exp_irq.push_back({2'b11, d});
    snd(fw(`FCD_OP_IRQ_SLEEP, 1'b0, 6'h0, 3'h0, 1'b0), 1'b1);
    chk(sleeping, 1'b1);
    apb(1'b0, `FCD_ADDR_STATUS, 32'h0);
    chk(rd[24], 1'b1);
    apb(1'b1, `FCD_ADDR_WAKE, 32'h1);
    @(negedge pclk);
    chk(sleeping, 1'b0);
    endtest("irq");
    apb(1'b1, 8'h40, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, `FCD_ADDR_ERR, 32'h1f);
    snd(fw(`FCD_OP_QUAD_POP, 1'b0, 6'h0, 3'h2, 1'b0), 1'b1);
    apb(1'b0, `FCD_ADDR_ERR, 32'h0);
    chk(rd[0], 1'b1);
    in_loop <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, `FCD_ADDR_ERR, 32'h1f);
      snd(fw(i ? `FCD_OP_QUAD_REVIVE : `FCD_OP_THR_REVIVE, 1'b0, 6'h0, 3'h0, 1'b0), 1'b1);
      apb(1'b0, `FCD_ADDR_ERR, 32'h0);
      chk(rd[3], 1'b1);
    end
    in_loop <= 1'b0;
    endtest("refuse");
    c = 6'($urandom);
    snd(fw(`FCD_OP_SET_PRIO, 1'b0, 6'h01, 3'h0, 1'b0), 1'b0);
    snd(fw(`FCD_OP_SET_PRIO, 1'b0, 6'h02, 3'h0, 1'b0), 1'b0);
    chk(prio, 6'h02);
    fork
      snd(fw(`FCD_OP_SET_PRIO, 1'b1, c, 3'h0, 1'b0), 1'b1);
      begin
        wait (instr_valid === 1'b1);
        repeat (3) @(negedge pclk) chk({instr_ready, prio}, {1'b0, 6'h02});
        u_seq.retire();
        u_seq.retire();
      end
    join
    chk(prio, c);
    endtest("barrier");
    summarize();
  end
endmodule
